// [core/adc_pkg.sv]
// shared types and constants for the converter host interface
package adc_pkg;

  // ********************************************
  // register map and widths
  // ********************************************
  localparam int          DATA_W      = 10;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [1:0]  SEL_SETUP   = 2'h0;
  localparam logic [1:0]  SEL_OUTPUT  = 2'h1;
  localparam logic [9:0]  SETUP_RESET = 10'h020;
  localparam logic [9:0]  OUTPUT_RESET = 10'h000;
  localparam logic [3:0]  PIPE_LATENCY = 4'h7;
  localparam logic [4:0]  LEVEL_ONE   = 5'h01;

  // ********************************************
  // register layouts, bit 9 first
  // ********************************************
  typedef struct packed {
    logic       diagnostic_sel_hi;
    logic       diagnostic_sel_lo;
    logic       autoscan;
    logic       diff_count_hi;
    logic       diff_count_lo;
    logic       input_select_hi;
    logic       input_select_lo;
    logic       power_down_bit;
    logic       single_mode;
    logic       ext_reference;
  } setup_reg_t;

  typedef struct packed {
    logic       reserved;
    logic       offset;
    logic       code_format_select;
    logic       read_write;
    logic       pin_polarity;
    logic       pin_type;
    logic       fill_threshold_hi;
    logic       fill_threshold_lo;
    logic       buffer_clear;
    logic       device_reset;
  } output_reg_t;

  // host strobes and register select
  typedef struct packed {
    logic       chip_select_low_active_n;
    logic       chip_select_high_active;
    logic       read_n;
    logic       write_n;
    logic       reg_select_msb;
    logic       reg_select_lsb;
  } host_bus_t;

endpackage

// [core/adc_result_port.sv]
// result fifo, output format and control registers of the converter
//
// Contract
// - format bit picks binary or twos complement
// - single-ended binary: 3FF, 200, 000
// - single-ended twos: 1FF, 000, 200
// - differential binary: 3FF, 200, 000
// - differential twos: 1FF, 000, 200
// - sixteen-entry circular fifo, filled automatically
// - read, write and trigger pointers kept
// - blocks start with first scanned channel
// - ready once written count reaches level
// - trigger levels depend on channel count
// - level one gives active-low pulse
// - read needs both selects and strobe
// - two ten-bit control registers
// - setup register field layout
// - output register field layout
// - select 00 setup, 01 output, rest reserved
// - setup register is write only
// - bit 1 set selects single mode
// - continuous mode delays first ready after buffer clear 7+level
// - no ready indication in test modes
`timescale 1ns/1ps

// ********************************************
// circular buffer
// ********************************************
module result_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             clear_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [$clog2(DEPTH)-1:0] last_written_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  assign in_ready_o     = (fill != DEPTH[AW:0]);
  assign out_valid_o    = (fill != '0);
  assign out_data_o     = mem[rd_ptr];
  assign last_written_o = wr_ptr - 1'b1;
  assign push           = in_valid_i & in_ready_o;
  assign pop            = out_valid_o & out_ready_i;

  always_comb begin
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_fill   = fill;
    if (clear_i) begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_fill   = '0;
    end else begin
      if (push) next_wr_ptr = wr_ptr + 1'b1;
      if (pop) next_rd_ptr = rd_ptr + 1'b1;
      next_fill = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      fill   <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      fill   <= next_fill;
    end
    if (push && !clear_i) mem[wr_ptr] <= in_data_i;
  end
endmodule

// ********************************************
// host interface top
// ********************************************
module adc_result_port #(
  parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // host bus
  input  adc_pkg::host_bus_t     host_bus_i,
  input  wire logic [9:0]        host_data_i,
  output logic [9:0]             host_data_o,
  output logic                   host_data_oe_o,
  output logic                   result_block_ready_n_o,
  // converter core
  input  wire logic              conversion_clock_in_i,
  input  wire logic              sample_valid_i,
  input  wire logic [9:0]        sample_code_i,
  output logic                   sample_ready_o,
  // mode outputs
  output adc_pkg::setup_reg_t    setup_o,
  output adc_pkg::output_reg_t   output_cfg_o,
  output logic                   buffer_clear_o
);
  localparam int AW = $clog2(DEPTH);

  adc_pkg::setup_reg_t  setup, next_setup;
  adc_pkg::output_reg_t outcfg, next_outcfg;
  logic       rd_prev, next_rd_prev;
  logic       wr_prev, next_wr_prev;
  logic [9:0] data_q, next_data_q;
  logic       clr, next_clr;
  logic [4:0] since_trig, next_since_trig;
  logic [AW-1:0] trig_ptr, next_trig_ptr;
  logic       pending, next_pending;
  logic [4:0] lat_cnt, next_lat_cnt;
  logic       lat_done, next_lat_done;
  logic       cclk_prev, next_cclk_prev;

  logic       rd_access;
  logic       wr_access;
  logic       rd_start;
  logic       wr_start;
  logic [1:0] sel;
  logic       push;
  logic       pop;
  logic       fifo_valid;
  logic [9:0] fifo_data;
  logic [4:0] level;
  logic       trig_now;
  logic       test_mode;

  // converts raw offset-binary code to the selected format
  function automatic logic [9:0] format_code(input logic [9:0] raw,
                                             input logic twos);
    format_code = twos ? {~raw[9], raw[8:0]} : raw;
  endfunction

  // trigger level from threshold code and enabled channel count
  function automatic logic [4:0] trigger_level(input logic [1:0] code,
                                               input logic [2:0] chans);
    logic [4:0] n;
    n = {2'h0, chans};
    if (chans == 3'h1) begin
      unique case (code)
        2'h0: trigger_level = 5'h01;
        2'h1: trigger_level = 5'h04;
        2'h2: trigger_level = 5'h08;
        default: trigger_level = 5'h0E;
      endcase
    end else begin
      trigger_level = 5'((n * ({3'h0, code} + 5'h01)) & 5'h1F);
    end
  endfunction

  // ********************************************
  // host access decode
  // ********************************************
  assign rd_access = !host_bus_i.chip_select_low_active_n
                   && host_bus_i.chip_select_high_active
                   && !host_bus_i.read_n;
  assign wr_access = !host_bus_i.chip_select_low_active_n
                   && host_bus_i.chip_select_high_active
                   && !host_bus_i.write_n;
  assign rd_start  = rd_access && !rd_prev;
  assign wr_start  = wr_access && !wr_prev;
  assign sel = {host_bus_i.reg_select_msb, host_bus_i.reg_select_lsb};
  assign pop = rd_start && (sel != adc_pkg::SEL_OUTPUT) && fifo_valid;
  assign push = sample_valid_i && sample_ready_o;
  assign test_mode = setup.diagnostic_sel_hi || setup.diagnostic_sel_lo;
  assign level = trigger_level({outcfg.fill_threshold_hi,
                                outcfg.fill_threshold_lo},
                               setup.autoscan
                                 ? 3'({setup.input_select_hi,
                                       setup.input_select_lo}) + 3'h1
                                 : 3'h1);
  assign trig_now = push && (since_trig + 5'h01 >= level);

  assign host_data_o    = data_q;
  assign host_data_oe_o = rd_access;
  assign setup_o        = setup;
  assign output_cfg_o   = outcfg;
  assign buffer_clear_o = clr;
  assign result_block_ready_n_o =
    !(pending && lat_done && !test_mode);

  result_fifo #(
    .WIDTH (10),
    .DEPTH (DEPTH)
  ) fifo_u (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .clear_i        (clr),
    .in_valid_i     (sample_valid_i),
    .in_ready_o     (sample_ready_o),
    .in_data_i      (sample_code_i),
    .out_valid_o    (fifo_valid),
    .out_ready_i    (pop),
    .out_data_o     (fifo_data),
    .last_written_o ()
  );

  // ********************************************
  // registers, read data, trigger tracking
  // ********************************************
  always_comb begin
    next_setup      = setup;
    next_outcfg     = outcfg;
    next_rd_prev    = rd_access;
    next_wr_prev    = wr_access;
    next_data_q     = data_q;
    next_clr        = 1'b0;
    next_since_trig = since_trig;
    next_trig_ptr   = trig_ptr;
    next_pending    = pending;
    next_lat_cnt    = lat_cnt;
    next_lat_done   = lat_done;
    next_cclk_prev  = conversion_clock_in_i;
    if (wr_start) begin
      unique case (sel)
        adc_pkg::SEL_SETUP: next_setup = host_data_i;
        adc_pkg::SEL_OUTPUT: begin
          next_outcfg = host_data_i;
          next_outcfg.buffer_clear = 1'b0;
          next_outcfg.device_reset = 1'b0;
          next_clr = host_data_i[1] || host_data_i[0];
          if (host_data_i[0]) begin
            next_setup  = adc_pkg::SETUP_RESET;
            next_outcfg = adc_pkg::OUTPUT_RESET;
          end
        end
        default: ;
      endcase
    end
    if (rd_start) begin
      // the setup register is never driven back
      if (sel == adc_pkg::SEL_OUTPUT) next_data_q = outcfg;
      else if (fifo_valid) begin
        next_data_q = format_code(fifo_data,
                                  outcfg.code_format_select);
      end
    end
    if (pending && (level == adc_pkg::LEVEL_ONE || pop)) begin
      next_pending = 1'b0;
    end
    if (push) next_since_trig = since_trig + 5'h01;
    if (trig_now) begin
      next_since_trig = since_trig + 5'h01 - level;
      next_trig_ptr   = trig_ptr + AW'(level);
      next_pending    = 1'b1;
    end
    if (!lat_done && conversion_clock_in_i && !cclk_prev) begin
      next_lat_cnt = lat_cnt + 5'h01;
      if (lat_cnt + 5'h01 >= {1'b0, adc_pkg::PIPE_LATENCY} + level) begin
        next_lat_done = 1'b1;
      end
    end
    if (clr) begin
      next_since_trig = '0;
      next_trig_ptr   = '0;
      next_pending    = 1'b0;
      next_lat_cnt    = '0;
      next_lat_done   = setup.single_mode;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      setup      <= adc_pkg::SETUP_RESET;
      outcfg     <= adc_pkg::OUTPUT_RESET;
      rd_prev    <= 1'b0;
      wr_prev    <= 1'b0;
      data_q     <= 10'h000;
      clr        <= 1'b0;
      since_trig <= '0;
      trig_ptr   <= '0;
      pending    <= 1'b0;
      lat_cnt    <= '0;
      lat_done   <= 1'b1;
      cclk_prev  <= 1'b0;
    end else begin
      setup      <= next_setup;
      outcfg     <= next_outcfg;
      rd_prev    <= next_rd_prev;
      wr_prev    <= next_wr_prev;
      data_q     <= next_data_q;
      clr        <= next_clr;
      since_trig <= next_since_trig;
      trig_ptr   <= next_trig_ptr;
      pending    <= next_pending;
      lat_cnt    <= next_lat_cnt;
      lat_done   <= next_lat_done;
      cclk_prev  <= next_cclk_prev;
    end
  end

  // ********************************************
  // checks
  // ********************************************
  chk_fmt_twos: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    pop && outcfg.code_format_select |=>
      host_data_o == {~$past(fifo_data[9]), $past(fifo_data[8:0])})
    else $error("twos complement code wrong");

  chk_fmt_binary: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    pop && !outcfg.code_format_select |=> host_data_o == $past(fifo_data))
    else $error("binary code wrong");

  chk_read_gate: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    rd_start && sel != adc_pkg::SEL_OUTPUT && !fifo_valid
      |=> $stable(host_data_o))
    else $error("empty read changed read data");

  chk_test_quiet: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    test_mode |-> result_block_ready_n_o)
    else $error("ready indicated in test mode");

  chk_setup_write: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    wr_start && sel == adc_pkg::SEL_SETUP |=>
      setup == $past(host_data_i))
    else $error("setup register not written");

  chk_clear_empty: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    wr_start && sel == adc_pkg::SEL_OUTPUT && host_data_i[1]
      |=> ##1 !fifo_valid && since_trig == 5'h00)
    else $error("buffer clear left data");

  chk_pulse_one: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    pending && level == adc_pkg::LEVEL_ONE && !trig_now && !clr
      |=> !pending)
    else $error("level one indication not a pulse");

  chk_latency_mask: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    clr && !setup.single_mode |=> !lat_done [*2])
    else $error("pipeline latency not applied");
endmodule

// [verif/host_model.sv]
// host processor model on the parallel result port
`timescale 1ns/1ps

module host_model (
  // clock
  input  wire logic          sys_clk_i,
  // host bus
  output adc_pkg::host_bus_t host_bus_o,
  output logic [9:0]         host_data_o,
  input  wire logic [9:0]    host_data_i,
  input  wire logic          host_data_oe_i
);
  // ****************************************
  // bus cycles, idle strobes between them
  // ****************************************
  initial begin
    host_bus_o  = 6'h2C;
    host_data_o = 10'h155;
  end

  task automatic wr(input logic [1:0] sel, input logic [9:0] d);
    @(posedge sys_clk_i);
    host_bus_o  <= {4'h6, sel};
    host_data_o <= d;
    repeat (2) @(posedge sys_clk_i);
    host_bus_o  <= 6'h2C;
    host_data_o <= ~d;
  endtask

  // data held until next read start, taken late
  task automatic rd(input logic [1:0] sel, output logic [9:0] d,
                    output logic oe);
    @(posedge sys_clk_i);
    host_bus_o <= {4'h5, sel};
    repeat (3) @(posedge sys_clk_i);
    d  = host_data_i;
    oe = host_data_oe_i;
    host_bus_o <= 6'h2C;
  endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench for the result port
`timescale 1ns/1ps

module tb_top;
  logic                 sys_clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  adc_pkg::host_bus_t   host_bus;
  logic [9:0]           host_wdata;
  logic [9:0]           host_rdata;
  logic                 host_oe;
  logic                 ready_n;
  logic                 conversion_clock_in = 1'b0;
  logic                 conv_run = 1'b0;
  logic                 s_valid = 1'b0;
  logic [9:0]           s_code = 10'h000;
  logic                 s_ready;
  logic                 buf_clr;
  int                   clr_cnt = 0;
  adc_pkg::setup_reg_t  setup;
  adc_pkg::output_reg_t out_cfg;
  int                   error_cnt = 0;
  int                   total_checks = 0;
  int                   low_cnt = 0;
  integer               seed = 32'h7cb7;
  logic [9:0]           q[$];
  logic [9:0]           last_rd = 10'h000;
  logic                 fmt = 1'b0;

  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) conversion_clock_in <= conv_run & ~conversion_clock_in;
  always @(posedge sys_clk_i) if (ready_n === 1'b0) low_cnt <= low_cnt + 1;
  always @(posedge sys_clk_i) if (buf_clr === 1'b1) clr_cnt <= clr_cnt + 1;

  adc_result_port i_adc_result_port (
    .sys_clk_i              (sys_clk_i),
    .reset_i                (reset_i),
    .host_bus_i             (host_bus),
    .host_data_i            (host_wdata),
    .host_data_o            (host_rdata),
    .host_data_oe_o         (host_oe),
    .result_block_ready_n_o (ready_n),
    .conversion_clock_in_i  (conversion_clock_in),
    .sample_valid_i         (s_valid),
    .sample_code_i          (s_code),
    .sample_ready_o         (s_ready),
    .setup_o                (setup),
    .output_cfg_o           (out_cfg),
    .buffer_clear_o         (buf_clr)
  );

  host_model i_host_model (
    .sys_clk_i      (sys_clk_i),
    .host_bus_o     (host_bus),
    .host_data_o    (host_wdata),
    .host_data_i    (host_rdata),
    .host_data_oe_i (host_oe)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] e,
                     input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // model keeps up to 16 entries, refuses beyond
  task automatic push(input logic [9:0] c);
    @(posedge sys_clk_i);
    s_valid <= 1'b1;
    s_code  <= c;
    @(posedge sys_clk_i);
    s_valid <= 1'b0;
    if (q.size() < 16) q.push_back(c);
  endtask

  // empty read leaves the last data standing
  task automatic pop();
    logic [9:0] d;
    logic       oe;
    i_host_model.rd(2'h0, d, oe);
    if (q.size() > 0) last_rd = q.pop_front() ^ {fmt, 9'h000};
    chk("fifo_data", last_rd, d);
    chk("read_enable", 10'h001, {9'h000, oe});
  endtask

  task automatic cfg(input logic [9:0] s, input logic [9:0] o);
    logic [9:0] d;
    logic       oe;
    int         cbase;
    cbase = clr_cnt;
    i_host_model.wr(2'h0, s);
    i_host_model.wr(2'h1, o);
    fmt = o[7];
    if (o[1]) q.delete();
    i_host_model.wr(2'h2, 10'h3FF);
    i_host_model.rd(2'h1, d, oe);
    last_rd = o & 10'h3FC;
    chk("setup_reg", s, setup);
    chk("output_reg", last_rd, d);
    chk("output_cfg", last_rd, out_cfg);
    chk("buffer_clear", {9'h000, o[1]}, 10'(clr_cnt - cbase));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    idle(20000);
    error_cnt++;
    complete_run();
  end

  initial begin
    int base;
    int lvl[4];
    lvl = '{1, 4, 8, 14};
    idle(3);
    reset_i <= 1'b0;
    idle(1);
    chk("setup_reset", adc_pkg::SETUP_RESET, setup);
    chk("output_reset", adc_pkg::OUTPUT_RESET, out_cfg);
    chk("empty_ready", 10'h001, {9'h000, s_ready});
    for (int f = 0; f < 2; f++) begin
      cfg(10'h002, {2'h0, f[0], 7'h02});
      push(10'h3FF);
      push(10'h200);
      push(10'h000);
      push(10'($random(seed)));
      repeat (4) pop();
    end
    cfg(10'h002, 10'h00E);
    repeat (5) begin
      push(10'($random(seed)));
      pop();
    end
    repeat (17) push(10'($random(seed)));
    chk("full_ready", 10'h000, {9'h000, s_ready});
    repeat (17) pop();
    for (int k = 0; k < 4; k++) begin
      cfg(10'h002, {6'h00, k[1:0], 2'h2});
      base = low_cnt;
      repeat (lvl[k] - 1) push(10'($random(seed)));
      idle(3);
      chk("early_ready", 10'h000, 10'(low_cnt - base));
      push(10'($random(seed)));
      idle(3);
      if (k == 0) chk("pulse_len", 10'h001, 10'(low_cnt - base));
      else chk("block_ready", 10'h000, {9'h000, ready_n});
      repeat (lvl[k]) pop();
    end
    conv_run <= 1'b1;
    cfg(10'h000, 10'h002);
    base = low_cnt;
    push(10'h155);
    idle(3);
    chk("masked_ready", 10'h000, 10'(low_cnt - base));
    idle(20);
    push(10'h2AA);
    idle(3);
    chk("late_ready", 10'h001, 10'(low_cnt - base));
    repeat (2) pop();
    cfg(10'h102, 10'h002);
    base = low_cnt;
    push(10'h0F0);
    idle(3);
    chk("test_ready", 10'h000, 10'(low_cnt - base));
    pop();
    complete_run();
  end
endmodule
